// >>> hw/rdv_pkg.sv
// Purpose: Shared constants for the calendar date and alarm value register block
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes:   Date and time digit fields are BCD; unimplemented bits read as zero
// ============================================================
// Package
package rdv_pkg;

  // ============================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CLOCK_CTRL = 8'h00;
  localparam logic [7:0] OFS_ALARM_CTRL = 8'h04;
  localparam logic [7:0] OFS_DATE       = 8'h08;
  localparam logic [7:0] OFS_ALRM_TIME  = 8'h0C;
  localparam logic [7:0] OFS_ALRM_DATE  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;

  // ============================================================
  // Field positions, digit fields are four bits wide
  localparam int DIG_W          = 4;
  localparam int POS_HI_TENS    = 28;   // Year tens, hour tens
  localparam int POS_HI_UNITS   = 24;   // Year units, hour units
  localparam int POS_MID_TENS   = 20;   // Month tens, minute tens
  localparam int POS_MID_UNITS  = 16;   // Month units, minute units
  localparam int POS_LO_TENS    = 12;   // Day tens, second tens
  localparam int POS_LO_UNITS   = 8;    // Day units, second units
  localparam int POS_WEEKDAY    = 0;    // Weekday digit
  localparam int POS_CWE        = 3;    // Calendar write enable in clock control
  localparam int POS_AEN        = 15;   // Alarm enable
  localparam int POS_CHIME      = 14;   // Repeat counter wrap
  localparam int POS_ALARM_PERIOD_MASK      = 8;    // Alarm period mask, four bits
  localparam int POS_ALARM_REPEAT_COUNTER       = 0;    // Alarm repeat counter, eight bits
  localparam int STAT_W         = 2;
  localparam int STAT_EVENT     = 0;    // Alarm event happened
  localparam int STAT_EXPIRED   = 1;    // Alarm disabled itself after last repeat

  // ============================================================
  // Implemented bit masks
  localparam logic [31:0] DATE_WMASK  = 32'hFFFF_FF0F;
  localparam logic [31:0] ATIME_WMASK = 32'hFFFF_FF00;
  localparam logic [31:0] ADATE_WMASK = 32'h00FF_FF0F;

  // ============================================================
  // Reset values
  localparam logic [31:0] DATE_RST    = 32'h0000_0000;
  localparam logic [31:0] ATIME_RST   = 32'h0000_0000;
  localparam logic [31:0] ADATE_RST   = 32'h0000_0000;
  localparam logic [3:0]  ALARM_PERIOD_MASK_RST   = 4'h0;
  localparam logic [7:0]  ALARM_REPEAT_COUNTER_RST    = 8'h00;
  localparam logic [1:0]  STAT_RST    = 2'h0;

  // ============================================================
  // Alarm period codes
  typedef enum logic [3:0] {
    RDV_PER_HALF_SEC = 4'h0,
    RDV_PER_SEC      = 4'h1,
    RDV_PER_10_SEC   = 4'h2,
    RDV_PER_MIN      = 4'h3,
    RDV_PER_10_MIN   = 4'h4,
    RDV_PER_HOUR     = 4'h5,
    RDV_PER_DAY      = 4'h6,
    RDV_PER_WEEK     = 4'h7,
    RDV_PER_MONTH    = 4'h8,
    RDV_PER_YEAR     = 4'h9
  } rdv_period_t;

endpackage : rdv_pkg

// >>> hw/rdv_alarm_match.sv
// Purpose: Compares running time and date with the alarm fields chosen by the period mask
// Assumes: All inputs on the same clock, purely combinational
// Notes:   Reserved mask codes never match
// ============================================================
// Alarm compare
module rdv_alarm_match (
  // Period selection
  input  wire logic [3:0]  period_mask,
  input  wire logic        half_second_phase,
  // Running values
  input  wire logic [31:0] cur_time,
  input  wire logic [31:0] cur_date,
  // Alarm values
  input  wire logic [31:0] alrm_time,
  input  wire logic [31:0] alrm_date,
  // Result
  output logic             match
);

  logic [8:0] eq;   // Per-digit equality, finest first

  // Equality of each compared digit
  always_comb begin
    eq[0] = ~half_second_phase;
    eq[1] = cur_time[rdv_pkg::POS_LO_UNITS +: rdv_pkg::DIG_W]
            == alrm_time[rdv_pkg::POS_LO_UNITS +: rdv_pkg::DIG_W];
    eq[2] = cur_time[rdv_pkg::POS_LO_TENS +: rdv_pkg::DIG_W]
            == alrm_time[rdv_pkg::POS_LO_TENS +: rdv_pkg::DIG_W];
    eq[3] = cur_time[rdv_pkg::POS_MID_UNITS +: rdv_pkg::DIG_W]
            == alrm_time[rdv_pkg::POS_MID_UNITS +: rdv_pkg::DIG_W];
    eq[4] = cur_time[rdv_pkg::POS_MID_TENS +: rdv_pkg::DIG_W]
            == alrm_time[rdv_pkg::POS_MID_TENS +: rdv_pkg::DIG_W];
    eq[5] = cur_time[31:24] == alrm_time[31:24];
    eq[6] = cur_date[rdv_pkg::POS_WEEKDAY +: rdv_pkg::DIG_W]
            == alrm_date[rdv_pkg::POS_WEEKDAY +: rdv_pkg::DIG_W];
    eq[7] = cur_date[15:8] == alrm_date[15:8];
    eq[8] = cur_date[23:16] == alrm_date[23:16];
  end

  // Each longer period adds the next digit group; month and year use day and month instead of weekday
  always_comb begin
    unique case (period_mask)
      rdv_pkg::RDV_PER_HALF_SEC: match = 1'b1;
      rdv_pkg::RDV_PER_SEC:      match = eq[0];
      rdv_pkg::RDV_PER_10_SEC:   match = &eq[1:0];
      rdv_pkg::RDV_PER_MIN:      match = &eq[2:0];
      rdv_pkg::RDV_PER_10_MIN:   match = &eq[3:0];
      rdv_pkg::RDV_PER_HOUR:     match = &eq[4:0];
      rdv_pkg::RDV_PER_DAY:      match = &eq[5:0];
      rdv_pkg::RDV_PER_WEEK:     match = &eq[6:0];
      rdv_pkg::RDV_PER_MONTH:    match = (&eq[5:0]) & eq[7];
      rdv_pkg::RDV_PER_YEAR:     match = (&eq[5:0]) & eq[7] & eq[8];
      default:                   match = 1'b0;   // Reserved codes
    endcase
  end

endmodule : rdv_alarm_match

// >>> hw/rdv_regs.sv
// Purpose: Calendar date and alarm value registers with alarm event logic on APB
// Assumes: half_second_tick and running time come from logic on mclk
// Notes:   Zero-wait APB slave, answer registered; one level interrupt output
// ============================================================
// Top module

module rdv_regs #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  // Running time from the rest of the unit
  input  wire logic              half_second_tick,
  input  wire logic              half_second_phase,
  input  wire logic [31:0]       cur_time,
  // To the rest of the unit
  output logic [31:0]            date_value,
  output logic                   calendar_write_enable,
  output logic                   alarm_event,
  output logic                   irq
);

  // ============================================================
  // State
  typedef struct packed {
    logic                      cwe;
    logic                      aen;
    logic                      chime;
    logic [3:0]                alarm_period_mask;
    logic [7:0]                alarm_repeat_counter;
    logic [31:0]               date;
    logic [31:0]               atime;
    logic [31:0]               adate;
    logic [rdv_pkg::STAT_W-1:0] status;
    logic [rdv_pkg::STAT_W-1:0] imask;
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    logic                      evt;
    logic                      irq;
  } rdv_state_t;

  rdv_state_t st_reg;
  rdv_state_t st_next;
  logic       match;
  logic       acc_setup;
  logic       acc_done;
  logic       wr;
  logic       fire;
  logic [rdv_pkg::STAT_W-1:0] stat_set;
  logic [rdv_pkg::STAT_W-1:0] stat_clr;

  // ============================================================
  // Address decode helpers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    addr_hit = (b == rdv_pkg::OFS_CLOCK_CTRL) || (b == rdv_pkg::OFS_ALARM_CTRL) ||
               (b == rdv_pkg::OFS_DATE) || (b == rdv_pkg::OFS_ALRM_TIME) ||
               (b == rdv_pkg::OFS_ALRM_DATE) || (b == rdv_pkg::OFS_IRQ_STATUS) ||
               (b == rdv_pkg::OFS_IRQ_MASK);
  endfunction : addr_hit

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                            input rdv_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (8'(a))
      rdv_pkg::OFS_CLOCK_CTRL: w[rdv_pkg::POS_CWE] = s.cwe;
      rdv_pkg::OFS_ALARM_CTRL: begin
        w[rdv_pkg::POS_AEN]        = s.aen;
        w[rdv_pkg::POS_CHIME]      = s.chime;
        w[rdv_pkg::POS_ALARM_PERIOD_MASK +: 4] = s.alarm_period_mask;
        w[rdv_pkg::POS_ALARM_REPEAT_COUNTER +: 8]  = s.alarm_repeat_counter;
      end
      rdv_pkg::OFS_DATE:       w = s.date & rdv_pkg::DATE_WMASK;
      rdv_pkg::OFS_ALRM_TIME:  w = s.atime & rdv_pkg::ATIME_WMASK;
      rdv_pkg::OFS_ALRM_DATE:  w = s.adate & rdv_pkg::ADATE_WMASK;
      rdv_pkg::OFS_IRQ_STATUS: w[rdv_pkg::STAT_W-1:0] = s.status;
      rdv_pkg::OFS_IRQ_MASK:   w[rdv_pkg::STAT_W-1:0] = s.imask;
      default:                 w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction : read_word

  // ============================================================
  // Alarm compare against own date and the running time
  rdv_alarm_match u_match (
    .period_mask       (st_reg.alarm_period_mask),
    .half_second_phase (half_second_phase),
    .cur_time          (cur_time),
    .cur_date          (st_reg.date),
    .alrm_time         (st_reg.atime),
    .alrm_date         (st_reg.adate),
    .match             (match)
  );

  // ============================================================
  // Next-state logic
  always_comb begin
    st_next   = st_reg;
    acc_setup = psel & ~penable;
    acc_done  = psel & penable & st_reg.pready;
    wr        = acc_done & pwrite & addr_hit(paddr);
    stat_set  = '0;
    stat_clr  = '0;
    fire      = half_second_tick & st_reg.aen & match;
    // APB answer is latched at the setup edge
    st_next.pready = acc_setup;
    if (acc_setup) begin
      st_next.pslverr = ~addr_hit(paddr);
      st_next.prdata  = read_word(paddr, st_reg);
    end else if (acc_done) begin
      st_next.pslverr = 1'b0;
      st_next.prdata  = 32'h0000_0000;
    end
    // Register writes
    if (wr) begin
      case (8'(paddr))
        rdv_pkg::OFS_CLOCK_CTRL: st_next.cwe = pwdata[rdv_pkg::POS_CWE];
        rdv_pkg::OFS_ALARM_CTRL: begin
          st_next.aen   = pwdata[rdv_pkg::POS_AEN];
          st_next.chime = pwdata[rdv_pkg::POS_CHIME];
          st_next.alarm_period_mask = pwdata[rdv_pkg::POS_ALARM_PERIOD_MASK +: 4];
          st_next.alarm_repeat_counter  = pwdata[rdv_pkg::POS_ALARM_REPEAT_COUNTER +: 8];
        end
        rdv_pkg::OFS_DATE: begin
          if (st_reg.cwe) begin
            st_next.date = pwdata & rdv_pkg::DATE_WMASK;
          end
        end
        rdv_pkg::OFS_ALRM_TIME: st_next.atime = pwdata & rdv_pkg::ATIME_WMASK;
        rdv_pkg::OFS_ALRM_DATE: st_next.adate = pwdata & rdv_pkg::ADATE_WMASK;
        rdv_pkg::OFS_IRQ_STATUS: stat_clr = pwdata[rdv_pkg::STAT_W-1:0];
        rdv_pkg::OFS_IRQ_MASK:   st_next.imask = pwdata[rdv_pkg::STAT_W-1:0];
        default: st_next.cwe = st_reg.cwe;
      endcase
    end
    // Alarm event: count down repeats or disable on the last one
    st_next.evt = fire;
    if (fire) begin
      stat_set[rdv_pkg::STAT_EVENT] = 1'b1;
      if ((st_reg.alarm_repeat_counter == 8'h00) && !st_reg.chime) begin
        st_next.aen = 1'b0;
        stat_set[rdv_pkg::STAT_EXPIRED] = 1'b1;
      end else begin
        st_next.alarm_repeat_counter = st_reg.alarm_repeat_counter - 8'h01;                   // Wraps to FF only with chime
      end
    end
    // Sticky status, a new event wins over a clear
    st_next.status = (st_reg.status & ~stat_clr) | stat_set;
    st_next.irq    = |(st_next.status & st_next.imask);
  end

  // ============================================================
  // State register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg.cwe     <= 1'b0;
      st_reg.aen     <= 1'b0;
      st_reg.chime   <= 1'b0;
      st_reg.alarm_period_mask   <= rdv_pkg::ALARM_PERIOD_MASK_RST;
      st_reg.alarm_repeat_counter    <= rdv_pkg::ALARM_REPEAT_COUNTER_RST;
      st_reg.date    <= rdv_pkg::DATE_RST;
      st_reg.atime   <= rdv_pkg::ATIME_RST;
      st_reg.adate   <= rdv_pkg::ADATE_RST;
      st_reg.status  <= rdv_pkg::STAT_RST;
      st_reg.imask   <= rdv_pkg::STAT_RST;
      st_reg.pready  <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.prdata  <= 32'h0000_0000;
      st_reg.evt     <= 1'b0;
      st_reg.irq     <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign pready                = st_reg.pready;
  assign pslverr               = st_reg.pslverr;
  assign prdata                = st_reg.prdata;
  assign date_value            = st_reg.date;
  assign calendar_write_enable = st_reg.cwe;
  assign alarm_event           = st_reg.evt;
  assign irq                   = st_reg.irq;

  // ============================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Write strobe for a given offset
  logic wr_date;
  logic wr_atime;
  logic wr_adate;
  assign wr_date  = psel & penable & pready & pwrite & (8'(paddr) == rdv_pkg::OFS_DATE);
  assign wr_atime = psel & penable & pready & pwrite & (8'(paddr) == rdv_pkg::OFS_ALRM_TIME);
  assign wr_adate = psel & penable & pready & pwrite & (8'(paddr) == rdv_pkg::OFS_ALRM_DATE);

  property p_date_protect;
    wr_date && !calendar_write_enable |=> $stable(date_value);
  endproperty
  a_date_protect: assert property (p_date_protect)
    else $error("date changed while write protected");

  property p_date_write;
    wr_date && calendar_write_enable |=> date_value == ($past(pwdata) & 32'hFFFF_FF0F);
  endproperty
  a_date_write: assert property (p_date_write)
    else $error("date write not stored");

  property p_date_zero;
    date_value[7:4] == 4'h0;
  endproperty
  a_date_zero: assert property (p_date_zero)
    else $error("date bits 7:4 not zero");

  property p_atime_write;
    wr_atime |=> st_reg.atime == ($past(pwdata) & rdv_pkg::ATIME_WMASK);
  endproperty
  a_atime_write: assert property (p_atime_write)
    else $error("alarm time readback wrong");

  property p_adate_write;
    wr_adate |=> st_reg.adate == ($past(pwdata) & rdv_pkg::ADATE_WMASK);
  endproperty
  a_adate_write: assert property (p_adate_write)
    else $error("alarm date readback wrong");

  property p_oneshot;
    st_reg.evt == 1'b0 ##0 (fire && st_reg.alarm_repeat_counter == 8'h00 && !st_reg.chime)
      |=> !st_reg.aen && alarm_event ##1 !alarm_event;
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("alarm enable not cleared after last repeat");

  property p_countdown;
    fire && (st_reg.alarm_repeat_counter != 8'h00 || st_reg.chime)
      |=> st_reg.alarm_repeat_counter == 8'($past(st_reg.alarm_repeat_counter) - 8'h01);
  endproperty
  a_countdown: assert property (p_countdown)
    else $error("repeat counter not decremented");

  property p_reserved;
    st_reg.alarm_period_mask >= 4'hA |-> !fire;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("alarm fired on reserved mask");

  property p_event_cause;
    alarm_event |-> $past(half_second_tick) && $past(st_reg.aen) && $past(match);
  endproperty
  a_event_cause: assert property (p_event_cause)
    else $error("alarm event without cause");

  property p_irq;
    alarm_event && st_reg.imask[rdv_pkg::STAT_EVENT] |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level wrong");

  // APB answer timing
  property p_pready;
    psel && !penable |=> pready;
  endproperty
  a_pready: assert property (p_pready)
    else $error("no answer after setup cycle");

  property p_pready_once;
    pready |=> !pready;
  endproperty
  a_pready_once: assert property (p_pready_once)
    else $error("answer stood longer than one cycle");

  property p_unmapped;
    psel && !penable && !addr_hit(paddr) |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  // Unimplemented bits read as zero, date reads back as stored
  property p_atime_zero;
    pready && !pwrite && 8'(paddr) == rdv_pkg::OFS_ALRM_TIME |-> prdata[7:0] == 8'h00;
  endproperty
  a_atime_zero: assert property (p_atime_zero)
    else $error("alarm time low bits not zero");

  property p_adate_zero;
    pready && !pwrite && 8'(paddr) == rdv_pkg::OFS_ALRM_DATE
      |-> prdata[31:24] == 8'h00 && prdata[7:4] == 4'h0;
  endproperty
  a_adate_zero: assert property (p_adate_zero)
    else $error("alarm date unimplemented bits not zero");

  property p_date_read;
    pready && !pwrite && 8'(paddr) == rdv_pkg::OFS_DATE |-> prdata == date_value;
  endproperty
  a_date_read: assert property (p_date_read)
    else $error("date readback wrong");

  // Alarm status
  property p_expired;
    fire && st_reg.alarm_repeat_counter == 8'h00 && !st_reg.chime |=> st_reg.status[rdv_pkg::STAT_EXPIRED];
  endproperty
  a_expired: assert property (p_expired)
    else $error("expired status not set");

  property p_set_wins;
    fire |=> st_reg.status[rdv_pkg::STAT_EVENT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event status not set");

  c_date_write: cover property (wr_date && calendar_write_enable);
  c_reserved:   cover property (st_reg.alarm_period_mask >= 4'hA && half_second_tick && st_reg.aen);
  c_event:      cover property (alarm_event);
  c_oneshot:    cover property (fire && st_reg.alarm_repeat_counter == 8'h00 && !st_reg.chime);
  c_wrap:       cover property (fire && st_reg.alarm_repeat_counter == 8'h00 && st_reg.chime);

endmodule : rdv_regs

// >>> tb/rtc_date_alarm_value_regs_test.sv
// Purpose: Self-checking bench for the date and alarm value register block
// Assumes: Zero-wait APB slave, registered answers, alarm_event one cycle after the tick
// Notes:   Answers are taken at the rising edge that sees pready high
// ============================================================
// Bench top
module rtc_date_alarm_value_regs_test;
  timeunit 1ns;
  timeprecision 100ps;

  // Clock and reset
  logic        mclk;
  logic        sys_rst;
  // APB master side
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  // Running time
  logic        half_second_tick;
  logic        half_second_phase;
  logic [31:0] cur_time;
  // Block outputs
  logic [31:0] date_value;
  logic        calendar_write_enable;
  logic        alarm_event;
  logic        irq;
  int          n_errors;
  int          total_checks;
  int          cycles;

  rdv_regs #(.ADDR_W(8)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .half_second_tick(half_second_tick), .half_second_phase(half_second_phase),
    .cur_time(cur_time), .date_value(date_value),
    .calendar_write_enable(calendar_write_enable), .alarm_event(alarm_event), .irq(irq)
  );

  // ============================================================
  // Clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Hang guard, far above the length of the run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end

  // ============================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Let the committed write settle before the caller looks at outputs
    @(negedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0000_0000);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask : rd

  task automatic chk_irq(input logic exp);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : chk_irq

  // One compare instant; the event shows one cycle after the tick
  task automatic tick(input logic [31:0] t, input logic exp);
    @(posedge mclk);
    cur_time         <= t;
    half_second_tick <= 1'b1;
    @(posedge mclk);
    half_second_tick <= 1'b0;
    @(negedge mclk);
    chk({31'h0, alarm_event}, {31'h0, exp});
  endtask : tick

  // ============================================================
  // Scenarios
  task automatic t_reset;
    rd(rdv_pkg::OFS_DATE, 32'h0000_0000, 1'b0);
    rd(rdv_pkg::OFS_ALRM_TIME, rdv_pkg::ATIME_RST, 1'b0);
    rd(rdv_pkg::OFS_ALRM_DATE, rdv_pkg::ADATE_RST, 1'b0);
    rd(8'h1C, 32'h0000_0000, 1'b1);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_date;
    wr(rdv_pkg::OFS_DATE, 32'h2107_1503);
    rd(rdv_pkg::OFS_DATE, 32'h0000_0000, 1'b0);
    wr(rdv_pkg::OFS_CLOCK_CTRL, 32'h0000_0008);
    chk({31'h0, calendar_write_enable}, 32'h0000_0001);
    wr(rdv_pkg::OFS_DATE, 32'h9912_31F6);
    rd(rdv_pkg::OFS_DATE, 32'h9912_3106, 1'b0);
    chk(date_value, 32'h9912_3106);
    wr(rdv_pkg::OFS_CLOCK_CTRL, 32'h0000_0000);
    wr(rdv_pkg::OFS_DATE, 32'h0101_0100);
    chk(date_value, 32'h9912_3106);
    $display("test date done");
  endtask : t_date

  task automatic t_alarm_regs;
    logic [31:0] q;
    logic        e;
    wr(rdv_pkg::OFS_ALRM_TIME, 32'hFFFF_FFFF);
    rd(rdv_pkg::OFS_ALRM_TIME, 32'hFFFF_FF00, 1'b0);
    wr(rdv_pkg::OFS_ALRM_TIME, 32'h2359_59AB);
    rd(rdv_pkg::OFS_ALRM_TIME, 32'h2359_5900, 1'b0);
    wr(rdv_pkg::OFS_ALRM_DATE, 32'hFFFF_FFFF);
    rd(rdv_pkg::OFS_ALRM_DATE, 32'h00FF_FF0F, 1'b0);
    wr(rdv_pkg::OFS_ALRM_DATE, 32'hAB12_31F6);
    rd(rdv_pkg::OFS_ALRM_DATE, 32'h0012_3106, 1'b0);
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    rd(8'h1C, 32'h0000_0000, 1'b1);
    $display("test alarm registers done");
  endtask : t_alarm_regs

  // Daily alarm, one repeat, then self-disable and interrupt handling
  task automatic t_alarm_run;
    wr(rdv_pkg::OFS_ALRM_TIME, 32'h1234_5600);
    wr(rdv_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    wr(rdv_pkg::OFS_ALARM_CTRL, 32'h0000_8601);
    tick(32'h1234_5600, 1'b1);
    rd(rdv_pkg::OFS_ALARM_CTRL, 32'h0000_8600, 1'b0);
    chk_irq(1'b1);
    tick(32'h1234_5700, 1'b0);
    tick(32'h1234_5600, 1'b1);
    rd(rdv_pkg::OFS_ALARM_CTRL, 32'h0000_0600, 1'b0);
    rd(rdv_pkg::OFS_IRQ_STATUS, 32'h0000_0003, 1'b0);
    tick(32'h1234_5600, 1'b0);
    wr(rdv_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    chk_irq(1'b0);
    wr(rdv_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    chk_irq(1'b1);
    wr(rdv_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
    rd(rdv_pkg::OFS_IRQ_STATUS, 32'h0000_0000, 1'b0);
    chk_irq(1'b0);
    $display("test alarm run done");
  endtask : t_alarm_run

  // Every period code with all fields matching; reserved codes stay silent
  task automatic t_periods;
    logic [31:0] ctl;
    for (int c = 0; c < 16; c++) begin
      ctl = 32'h0000_C0FF | (32'(c) << rdv_pkg::POS_ALARM_PERIOD_MASK);
      wr(rdv_pkg::OFS_ALARM_CTRL, ctl);
      tick(32'h1234_5600, (c <= 9));
    end
    // Every-second code stays silent in the second half of a second
    wr(rdv_pkg::OFS_ALARM_CTRL, 32'h0000_C1FF);
    @(posedge mclk);
    half_second_phase <= 1'b1;
    tick(32'h1234_5600, 1'b0);
    @(posedge mclk);
    half_second_phase <= 1'b0;
    wr(rdv_pkg::OFS_ALARM_CTRL, 32'h0000_C5FF);
    tick(32'h0834_5600, 1'b1);
    wr(rdv_pkg::OFS_ALARM_CTRL, 32'h0000_C6FF);
    tick(32'h0834_5600, 1'b0);
    $display("test periods done");
  endtask : t_periods

  // ============================================================
  // Closing report
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    n_errors          = 0;
    total_checks      = 0;
    cycles            = 0;
    sys_rst           = 1'b1;
    psel              = 1'b0;
    penable           = 1'b0;
    pwrite            = 1'b0;
    paddr             = 8'h00;
    pwdata            = 32'h0000_0000;
    half_second_tick  = 1'b0;
    half_second_phase = 1'b0;
    cur_time          = 32'h0000_0000;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_date();
    t_alarm_regs();
    t_alarm_run();
    t_periods();
    test_done();
  end

endmodule : rtc_date_alarm_value_regs_test
